/* File: src/mls_memory_latency_sampler.v */
`include "mls_consts.vh"
module mls_memory_latency_sampler (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_n_i,
   // register port
   input  wire [3:0]  reg_addr_i,
   input  wire [31:0] reg_wdata_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   output wire [31:0] reg_rdata_o,
   // memory access pipeline
   input  wire        acc_dispatch_i,
   input  wire        acc_cache_start_i,
   input  wire        acc_data_return_i,
   input  wire        acc_retire_i,
   input  wire        acc_is_store_i,
   input  wire        acc_streaming_i,
   input  wire        acc_sw_prefetch_i,
   input  wire        acc_visible_i,
   input  wire [3:0]  acc_src_i,
   input  wire [7:0]  acc_aux_i,
   input  wire [31:0] acc_addr_i,
   // sample record out
   output wire        rec_valid_o,
   output wire        rec_is_store_o,
   output wire [3:0]  rec_src_o,
   output wire [7:0]  rec_aux_o,
   output wire [31:0] rec_addr_o,
   output wire [15:0] rec_inst_lat_o,
   output wire [15:0] rec_cache_lat_o
);

////////////////////////////////////////////////////////////////////////////////
// register map, word index on reg_addr_i:
//   0 event select 0, 1 event select 1
//   2 counter 0, 3 counter 1 (a write wins over a same-cycle count)
//   4 load threshold [15:0], resets to the minimum legal value
//   5 sample enable [1:0], one bit per counter
//   6 sample data config, bit 0 memory info
//   7 last record {aux, source}
//   8 last instruction latency, 9 last cache latency
//   10 last data address
//   other indices read zero and drop writes
// limitation: one access tracked at a time; a second dispatch while
// busy is taken as a re-dispatch of the tracked one
////////////////////////////////////////////////////////////////////////////////
// registers
reg [31:0] evsel0_reg;
reg [31:0] evsel1_reg;
reg [31:0] cnt0_reg;
reg [31:0] cnt1_reg;
reg [15:0] thresh_reg;
reg [1:0]  enable_reg;
reg [31:0] datacfg_reg;
reg [31:0] rdata_reg;
// measurement
reg        busy_reg;
reg        cache_run_reg;
reg        inst_run_reg;
reg [15:0] inst_lat_reg;
reg [15:0] cache_lat_reg;
// record
reg        rec_valid_reg;
reg        rec_is_store_reg;
reg [3:0]  rec_src_reg;
reg [7:0]  rec_aux_reg;
reg [31:0] rec_addr_reg;
reg [15:0] rec_inst_lat_reg;
reg [15:0] rec_cache_lat_reg;

// 16-bit latency fields: a stall beyond FFFF cycles reads as FFFF
// saturating increment so long misses never wrap to a small latency
function [15:0] mls_sat_inc;
   input [15:0] v;
   begin
      mls_sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
   end
endfunction

function mls_is_load_ev;
   input [31:0] sel;
   begin
      mls_is_load_ev = (sel[`MLS_EV_LO:0] == `MLS_EV_LOAD_LAT);
   end
endfunction

// every one of the sixteen codes is defined, so the case is total; an
// unknown value from the pipeline falls back to the unknown class
function [3:0] mls_src_class;
   input [3:0] code;
   input       pref;
   begin
      if (pref) begin
         mls_src_class = `MLS_SRC_L1;
      end else begin
         case (code)
            `MLS_SRC_UNKNOWN:   mls_src_class = `MLS_SRC_UNKNOWN;
            `MLS_SRC_L1:        mls_src_class = `MLS_SRC_L1;
            `MLS_SRC_FILLBUF:   mls_src_class = `MLS_SRC_FILLBUF;
            `MLS_SRC_L2:        mls_src_class = `MLS_SRC_L2;
            `MLS_SRC_L3:        mls_src_class = `MLS_SRC_L3;
            `MLS_SRC_SIB_MISS:  mls_src_class = `MLS_SRC_SIB_MISS;
            `MLS_SRC_SIB_CLEAN: mls_src_class = `MLS_SRC_SIB_CLEAN;
            `MLS_SRC_SIB_FWD:   mls_src_class = `MLS_SRC_SIB_FWD;
            `MLS_SRC_LFAR:      mls_src_class = `MLS_SRC_LFAR;
            `MLS_SRC_RFAR:      mls_src_class = `MLS_SRC_RFAR;
            `MLS_SRC_LNEAR:     mls_src_class = `MLS_SRC_LNEAR;
            `MLS_SRC_RNEAR:     mls_src_class = `MLS_SRC_RNEAR;
            `MLS_SRC_RFWD:      mls_src_class = `MLS_SRC_RFWD;
            `MLS_SRC_RMOD:      mls_src_class = `MLS_SRC_RMOD;
            `MLS_SRC_IO:        mls_src_class = `MLS_SRC_IO;
            `MLS_SRC_UNCACHE:   mls_src_class = `MLS_SRC_UNCACHE;
            default:            mls_src_class = `MLS_SRC_UNKNOWN;
         endcase
      end
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// latency measurement
// timing of one tracked access:
//   dispatch edge          instruction latency loads 1
//   each following edge    +1 until the data-return edge, inclusive
//   cache-start edge       cache latency starts counting
//   data-return edge       both counters stop
//   retire edge            decision taken, record loaded on that same edge
// a retire before data return compares the count including that edge,
// so a stalled load can still cross the threshold
wire [15:0] inst_lat_now = mls_sat_inc(inst_lat_reg);
wire [15:0] cache_lat_now = (cache_run_reg | acc_cache_start_i) ?
                            mls_sat_inc(cache_lat_reg) : cache_lat_reg;

always @(posedge clk_i) begin
   if (!rst_n_i) begin
      busy_reg      <= 1'b0;
      inst_run_reg  <= 1'b0;
      cache_run_reg <= 1'b0;
      inst_lat_reg  <= 16'h0000;
      cache_lat_reg <= 16'h0000;
   end else begin
      if (acc_dispatch_i && !busy_reg) begin
         // first dispatch starts the clock, re-dispatches keep it running
         busy_reg     <= 1'b1;
         inst_run_reg <= 1'b1;
         inst_lat_reg <= 16'h0001;
         cache_lat_reg <= 16'h0000;
         cache_run_reg <= 1'b0;
      end else if (busy_reg) begin
         if (inst_run_reg)
            inst_lat_reg <= inst_lat_now;
         if (acc_cache_start_i)
            cache_run_reg <= 1'b1;
         if (cache_run_reg | acc_cache_start_i)
            cache_lat_reg <= cache_lat_now;
         if (acc_data_return_i) begin
            inst_run_reg  <= 1'b0;
            cache_run_reg <= 1'b0;
         end
         if (acc_retire_i)
            busy_reg <= 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// sampling decision
wire load_ev0   = mls_is_load_ev(evsel0_reg);
wire load_ev1   = mls_is_load_ev(evsel1_reg);
wire store_ev0  = (evsel0_reg[`MLS_EV_LO:0] == `MLS_EV_STORE);
wire meminfo    = datacfg_reg[`MLS_MEMINFO_BIT];
wire retire     = acc_retire_i & busy_reg;
wire [15:0] fin_lat = inst_run_reg ? inst_lat_now : inst_lat_reg;
wire over_thr   = (fin_lat > thresh_reg);
wire load_ok    = retire & ~acc_is_store_i & acc_visible_i & over_thr;
// rfo and streaming stores are taken alike, no threshold applied
wire store_ok   = retire & acc_is_store_i & (acc_streaming_i | ~acc_streaming_i);
wire hit0_load  = load_ev0 & load_ok;
wire hit1_load  = load_ev1 & load_ok;
wire hit0_store = store_ev0 & store_ok;
wire smp_load   = meminfo & ((hit0_load & enable_reg[0]) | (hit1_load & enable_reg[1]));
wire smp_store  = meminfo & hit0_store & enable_reg[0];
// prefetches return early, so cache fields read as a first-level hit
wire [3:0]  src_eff  = mls_src_class(acc_src_i, acc_sw_prefetch_i);
wire [15:0] clat_eff = acc_sw_prefetch_i ? 16'h0001 :
                       (cache_run_reg ? cache_lat_now : cache_lat_reg);

// the record holds its fields until the next sample so software can read
// the last one back at leisure; rec_valid_o marks the refresh only
always @(posedge clk_i) begin
   if (!rst_n_i) begin
      rec_valid_reg     <= 1'b0;
      rec_is_store_reg  <= 1'b0;
      rec_src_reg       <= `MLS_SRC_UNKNOWN;
      rec_aux_reg       <= 8'h00;
      rec_addr_reg      <= 32'h00000000;
      rec_inst_lat_reg  <= 16'h0000;
      rec_cache_lat_reg <= 16'h0000;
   end else begin
      rec_valid_reg <= smp_load | smp_store;
      if (smp_load | smp_store) begin
         rec_is_store_reg  <= acc_is_store_i;
         // class already decoded, all sixteen codes defined
         rec_src_reg       <= src_eff;
         rec_aux_reg       <= acc_aux_i;
         rec_addr_reg      <= acc_addr_i;
         rec_inst_lat_reg  <= acc_is_store_i ? 16'h0000 : fin_lat;
         rec_cache_lat_reg <= clat_eff;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// register port and counters
// counting runs whether or not sampling is enabled, matching counters
// that software reads directly; read data stand one cycle only and read
// zero otherwise, so a stale value never looks like a fresh answer
wire wr_cnt0 = reg_wr_i & (reg_addr_i == `MLS_A_CNT0);
wire wr_cnt1 = reg_wr_i & (reg_addr_i == `MLS_A_CNT1);

always @(posedge clk_i) begin
   if (!rst_n_i) begin
      evsel0_reg  <= 32'h00000000;
      evsel1_reg  <= 32'h00000000;
      cnt0_reg    <= 32'h00000000;
      cnt1_reg    <= 32'h00000000;
      thresh_reg  <= `MLS_THRESH_MIN;
      enable_reg  <= 2'b00;
      datacfg_reg <= 32'h00000000;
      rdata_reg   <= 32'h00000000;
   end else begin
      if (reg_wr_i) begin
         case (reg_addr_i)
            `MLS_A_EVSEL0:  evsel0_reg  <= reg_wdata_i;
            `MLS_A_EVSEL1:  evsel1_reg  <= reg_wdata_i;
            `MLS_A_THRESH:  thresh_reg  <= reg_wdata_i[15:0];
            `MLS_A_ENABLE:  enable_reg  <= reg_wdata_i[1:0];
            `MLS_A_DATACFG: datacfg_reg <= reg_wdata_i;
            default: ;
         endcase
      end
      // a software write wins over a same-cycle count
      if (wr_cnt0)
         cnt0_reg <= reg_wdata_i;
      else if (hit0_load | hit0_store)
         cnt0_reg <= cnt0_reg + 32'h00000001;
      if (wr_cnt1)
         cnt1_reg <= reg_wdata_i;
      else if (hit1_load)
         cnt1_reg <= cnt1_reg + 32'h00000001;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `MLS_A_EVSEL0:   rdata_reg <= evsel0_reg;
            `MLS_A_EVSEL1:   rdata_reg <= evsel1_reg;
            `MLS_A_CNT0:     rdata_reg <= cnt0_reg;
            `MLS_A_CNT1:     rdata_reg <= cnt1_reg;
            `MLS_A_THRESH:   rdata_reg <= {16'h0000, thresh_reg};
            `MLS_A_ENABLE:   rdata_reg <= {30'h00000000, enable_reg};
            `MLS_A_DATACFG:  rdata_reg <= datacfg_reg;
            `MLS_A_LASTSRC:  rdata_reg <= {20'h00000, rec_aux_reg, rec_src_reg};
            `MLS_A_LASTLAT:  rdata_reg <= {16'h0000, rec_inst_lat_reg};
            `MLS_A_LASTCLAT: rdata_reg <= {16'h0000, rec_cache_lat_reg};
            `MLS_A_LASTADDR: rdata_reg <= rec_addr_reg;
            default:         rdata_reg <= 32'h00000000;
         endcase
      end else begin
         rdata_reg <= 32'h00000000;
      end
   end
end

assign reg_rdata_o     = rdata_reg;
assign rec_valid_o     = rec_valid_reg;
assign rec_is_store_o  = rec_is_store_reg;
assign rec_src_o       = rec_src_reg;
assign rec_aux_o       = rec_aux_reg;
assign rec_addr_o      = rec_addr_reg;
assign rec_inst_lat_o  = rec_inst_lat_reg;
assign rec_cache_lat_o = rec_cache_lat_reg;

endmodule // mls_memory_latency_sampler

/* File: src/mls_consts.vh */
`ifndef MLS_CONSTS_VH
`define MLS_CONSTS_VH
// register offsets
`define MLS_A_EVSEL0      4'h0
`define MLS_A_EVSEL1      4'h1
`define MLS_A_CNT0        4'h2
`define MLS_A_CNT1        4'h3
`define MLS_A_THRESH      4'h4
`define MLS_A_ENABLE      4'h5
`define MLS_A_DATACFG     4'h6
`define MLS_A_LASTSRC     4'h7
`define MLS_A_LASTLAT     4'h8
`define MLS_A_LASTCLAT    4'h9
`define MLS_A_LASTADDR    4'hA
// event codes in event select low bits
`define MLS_EV_LOAD_LAT   16'h01CD
`define MLS_EV_STORE      16'h02CD
`define MLS_EV_LO         15
`define MLS_COUNT_MASK_FIELD_HI      31
`define MLS_COUNT_MASK_FIELD_LO      24
`define MLS_INV_BIT       23
`define MLS_MEMINFO_BIT   0
`define MLS_THRESH_MIN    16'h0001
// origin classes
`define MLS_SRC_UNKNOWN   4'h0
`define MLS_SRC_L1        4'h1
`define MLS_SRC_FILLBUF   4'h2
`define MLS_SRC_L2        4'h3
`define MLS_SRC_L3        4'h4
`define MLS_SRC_SIB_MISS  4'h5
`define MLS_SRC_SIB_CLEAN 4'h6
`define MLS_SRC_SIB_FWD   4'h7
`define MLS_SRC_LFAR      4'h8
`define MLS_SRC_RFAR      4'h9
`define MLS_SRC_LNEAR     4'hA
`define MLS_SRC_RNEAR     4'hB
`define MLS_SRC_RFWD      4'hC
`define MLS_SRC_RMOD      4'hD
`define MLS_SRC_IO        4'hE
`define MLS_SRC_UNCACHE   4'hF
`endif

/* File: testbench/mls_sampler_asserts.sv */
module mls_sampler_asserts (
   input wire        clk_i,
   input wire        rst_n_i,
   input wire        acc_retire_i,
   input wire        acc_is_store_i,
   input wire        acc_sw_prefetch_i,
   input wire        acc_visible_i,
   input wire [3:0]  acc_src_i,
   input wire [7:0]  acc_aux_i,
   input wire [31:0] acc_addr_i,
   input wire        rec_valid_o,
   input wire        rec_is_store_o,
   input wire [3:0]  rec_src_o,
   input wire [31:0] rec_addr_o,
   input wire [7:0]  rec_aux_o,
   input wire [15:0] rec_inst_lat_o,
   input wire [15:0] rec_cache_lat_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_load; rec_valid_o && !rec_is_store_o; endsequence
   sequence s_fresh; rec_valid_o && !$past(acc_sw_prefetch_i); endsequence
   property p_cause; rec_valid_o |-> $past(acc_retire_i) && rec_addr_o == $past(acc_addr_i)
      && rec_aux_o == $past(acc_aux_i); endproperty
   a_cause: assert property (p_cause) else $error("record without matching retire");
   property p_pref; s_load ##0 $past(acc_sw_prefetch_i) |-> rec_src_o == 4'h1
      && rec_cache_lat_o == 16'h0001; endproperty
   a_pref: assert property (p_pref) else $error("prefetch fields wrong");
   property p_src; s_fresh |-> rec_src_o == $past(acc_src_i); endproperty
   a_src: assert property (p_src) else $error("source code wrong");
   property p_store; rec_valid_o && rec_is_store_o |-> rec_inst_lat_o == 16'h0000
      && $past(acc_is_store_i); endproperty
   a_store: assert property (p_store) else $error("store record wrong");
   property p_vis; s_load |-> $past(acc_visible_i) && !$past(acc_is_store_i); endproperty
   a_vis: assert property (p_vis) else $error("ineligible load recorded");
   property p_thr; s_load |-> rec_inst_lat_o > 16'h0001; endproperty
   a_thr: assert property (p_thr) else $error("load below minimum threshold");
   property p_clat; s_load |-> $past(acc_sw_prefetch_i) || rec_cache_lat_o < rec_inst_lat_o;
   endproperty
   a_clat: assert property (p_clat) else $error("cache latency above inst latency");
   property p_hold; !rec_valid_o |-> $stable(rec_addr_o) && $stable(rec_inst_lat_o); endproperty
   a_hold: assert property (p_hold) else $error("record fields moved");
endmodule // mls_sampler_asserts
////////////////////////////////////////////////////////////////
bind mls_memory_latency_sampler mls_sampler_asserts u_chk (.*);

/* File: testbench/mls_memory_latency_sampler_tb.sv */
`include "mls_consts.vh"
module mls_memory_latency_sampler_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, rst_n_i, reg_wr_i, reg_rd_i, acc_dispatch_i, acc_cache_start_i, rd_pend;
   logic        acc_data_return_i, acc_retire_i, acc_is_store_i, acc_streaming_i, ld;
   logic        acc_sw_prefetch_i, acc_visible_i, rec_valid_o, rec_is_store_o, hit;
   logic [3:0]  reg_addr_i, acc_src_i, rec_src_o;
   logic [7:0]  acc_aux_i, rec_aux_o;
   logic [15:0] rec_inst_lat_o, rec_cache_lat_o;
   logic [31:0] reg_wdata_i, reg_rdata_o, acc_addr_i, rec_addr_o, seed, cnt, thr;
   logic [76:0] rec_q[$];
   logic [31:0] rd_q[$];
   int          bad_count, tests_run;
   mls_memory_latency_sampler dut (.*);
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   ////////////////////////////////////////////////////////////////
   task automatic cmp_reg(logic [31:0] e);
      tests_run++;
      if (reg_rdata_o !== e) begin
         bad_count++;
         $display("Error reg_rdata_o expected %h seen %h", e, reg_rdata_o);
      end
   endtask
   task automatic cmp_rec(logic [76:0] e);
      logic [76:0] g;
      g = {rec_is_store_o, rec_src_o, rec_aux_o, rec_addr_o, rec_inst_lat_o, rec_cache_lat_o};
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("Error record expected %h seen %h", e, g);
      end
   endtask
   // outputs sampled before this edge's updates land
   always @(posedge clk_i) begin
      if (rd_pend === 1'b1) cmp_reg(rd_q.size() > 0 ? rd_q.pop_front() : '1);
      rd_pend <= reg_rd_i;
      if (rec_valid_o === 1'b1) cmp_rec(rec_q.size() > 0 ? rec_q.pop_front() : '1);
   end
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk_i);
      {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, logic [31:0] e);
      @(posedge clk_i);
      {reg_rd_i, reg_addr_i} <= {1'b1, a};
      rd_q.push_back(e);
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
   endtask
   // k cycles from cache start to data return, retire right after
   task automatic acc(logic s, logic f, logic p, logic v, int k, logic [3:0] src);
      logic [7:0]  aux;
      logic [31:0] adr;
      aux = 8'(rnd());
      adr = rnd();
      hit = ld ? (!s && v && 32'(k + 1) > thr) : s;
      @(posedge clk_i);
      acc_dispatch_i <= 1'b1;
      for (int c = 1; c <= k; c++) begin
         @(posedge clk_i);
         {acc_dispatch_i, acc_cache_start_i, acc_data_return_i} <= {1'b0, c == 1, c == k};
      end
      @(posedge clk_i);
      {acc_cache_start_i, acc_data_return_i, acc_retire_i} <= 3'b001;
      {acc_is_store_i, acc_streaming_i, acc_sw_prefetch_i, acc_visible_i} <= {s, f, p, v};
      {acc_src_i, acc_aux_i, acc_addr_i} <= {src, aux, adr};
      if (hit) rec_q.push_back({s, p ? 4'h1 : src, aux, adr, s ? 16'h0 : 16'(k + 1),
                                p ? 16'h1 : 16'(k)});
      cnt = cnt + 32'(hit);
      @(posedge clk_i);
      acc_retire_i <= 1'b0;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      {seed, cnt, thr, ld, rd_pend, bad_count, tests_run} = {32'h6, 32'h0, 32'h1, 1'b1, 1'b0, 64'h0};
      {reg_wr_i, reg_rd_i, acc_dispatch_i, acc_cache_start_i, acc_data_return_i} = '0;
      {acc_retire_i, acc_is_store_i, acc_streaming_i, acc_sw_prefetch_i, acc_visible_i} = '0;
      {reg_addr_i, acc_src_i, acc_aux_i, reg_wdata_i, acc_addr_i} = '0;
      rst_n_i = 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(`MLS_A_THRESH, 32'h1);
      rd(`MLS_A_CNT0, 32'h0);
      wr(4'hF, 32'hFFFF_FFFF);
      rd(4'hF, 32'h0);
      $display("test reset_and_unmapped done");
      wr(`MLS_A_EVSEL0, {16'h0, `MLS_EV_LOAD_LAT});
      wr(`MLS_A_EVSEL1, {16'h0, `MLS_EV_LOAD_LAT});
      wr(`MLS_A_THRESH, 32'h5);
      thr = 32'h5;
      wr(`MLS_A_DATACFG, 32'h1);
      wr(`MLS_A_ENABLE, 32'h1);
      for (int k = 3; k <= 5; k++) acc(0, 0, 0, 1, k, 4'(rnd()));
      acc(1, 0, 0, 1, 8, 4'h3);
      acc(0, 0, 0, 0, 8, 4'h3);
      for (int i = 0; i < 16; i++) acc(0, 0, 0, 1, 5 + i, 4'(i));
      acc(0, 0, 1, 1, 7, 4'hC);
      rd(`MLS_A_CNT0, cnt);
      rd(`MLS_A_CNT1, cnt);
      $display("test load_latency done");
      wr(`MLS_A_EVSEL0, {16'h0, `MLS_EV_STORE});
      ld = 1'b0;
      for (int i = 0; i < 4; i++) acc(1, i[0], 0, 1, 1 + i, 4'(rnd()));
      acc(0, 0, 0, 1, 9, 4'h1);
      rd(`MLS_A_CNT0, cnt);
      $display("test store_sampling done");
      repeat (4) @(posedge clk_i);
      if (rec_q.size() + rd_q.size() != 0) begin
         bad_count++;
         $display("Error pending expected 0 seen %0d", rec_q.size() + rd_q.size());
      end
      give_verdict();
   end
endmodule // mls_memory_latency_sampler_tb
